// File: verilog/rtb_pkg.sv
package rtb_pkg;

   ////////////////////////////////////////////////////////////////////////
   // register offsets
   localparam logic [7:0] ADDR_PRIMARY_CTRL = 8'h00;
   localparam logic [7:0] ADDR_FLAG_CTRL = 8'h01;
   localparam logic [7:0] ADDR_TMR_CLKOUT = 8'h0f;
   localparam logic [7:0] ADDR_TMR_B_FREQ = 8'h12;
   localparam logic [7:0] ADDR_TMR_B_VALUE = 8'h13;

   ////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned BIT_SEC_IRQ_EN = 2;
   localparam int unsigned BIT_B_IRQ_EN = 0;
   localparam int unsigned BIT_SEC_FLAG = 4;
   localparam int unsigned BIT_B_FLAG = 5;
   localparam int unsigned BIT_A_PULSE_SEL = 7;
   localparam int unsigned BIT_B_PULSE_SEL = 6;
   localparam int unsigned BIT_B_RUN = 0;
   localparam int unsigned SRC_LSB = 0;
   localparam int unsigned WIDTH_LSB = 4;
   localparam int unsigned SEL_W = 3;

   ////////////////////////////////////////////////////////////////////////
   // source clock codes and reset values
   localparam logic [2:0] SRC_4K = 3'h0;
   localparam logic [2:0] SRC_64 = 3'h1;
   localparam logic [2:0] SRC_1 = 3'h2;
   localparam logic [2:0] SRC_60 = 3'h3;
   localparam logic [2:0] SRC_RST = 3'h7;
   localparam logic [2:0] WIDTH_RST = 3'h0;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COUNT_LAST = 8'h01;
   localparam logic [7:0] COUNT_STOP = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // timing: pulse widths counted in 8.192 kHz ticks (122.07 us each)
   localparam int unsigned SYS_CLK_HZ = 125_000_000;
   localparam int unsigned TICK_HZ = 8192;
   localparam int unsigned CYC_TICK = SYS_CLK_HZ / TICK_HZ;
   localparam int unsigned TICKS_PER_4K = 2;
   localparam int unsigned TICKS_PER_64 = 128;
   localparam int unsigned P64_PER_SEC = 64;
   localparam int unsigned PER_MIN = 60;
   localparam logic [11:0] W_122US = 12'h001;
   localparam logic [11:0] W_244US = 12'h002;
   localparam logic [11:0] W_7812US = 12'h040;
   localparam logic [11:0] W_15625US = 12'h080;
   localparam logic [11:0] W_TBW_BASE = 12'h180;
   localparam int unsigned TBW_STEP_SHIFT = 8;
   localparam int unsigned P64_SHIFT = 7;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic sec_irq_en;
      logic b_irq_en;
      logic a_pulse_sel;
      logic b_pulse_sel;
      logic b_run;
      logic [2:0] b_width_sel;
      logic [2:0] b_src_sel;
   } rtb_ctrl_t;

   typedef struct packed {
      logic t8k;
      logic t4k;
      logic t64;
      logic t1;
      logic t60;
      logic t3600;
   } rtb_ticks_t;

endpackage

// File: verilog/rtb_prescaler.sv
`timescale 1ns/1ps
module rtb_prescaler #(
   parameter int unsigned CYC_TICK = rtb_pkg::CYC_TICK
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // one-cycle ticks of each source rate
   output rtb_pkg::rtb_ticks_t ticks_o
);

   logic [15:0] base_reg, base_next;
   logic [0:0] c4k_reg, c4k_next;
   logic [6:0] c64_reg, c64_next;
   logic [5:0] c1_reg, c1_next, cmin_reg, cmin_next, chr_reg, chr_next;
   rtb_pkg::rtb_ticks_t ticks_reg, ticks_next;

   function automatic logic [5:0] step6(input logic [5:0] c,
                                        input logic en);
      step6 = c;
      if (en) begin
         step6 = (c == 6'(rtb_pkg::PER_MIN - 1)) ? 6'h00 : c + 6'h01;
      end
   endfunction

   always_comb begin
      ticks_next.t8k = (base_reg == 16'(CYC_TICK - 1));
      ticks_next.t4k = ticks_next.t8k &&
                       (c4k_reg == 1'(rtb_pkg::TICKS_PER_4K - 1));
      ticks_next.t64 = ticks_next.t8k &&
                       (c64_reg == 7'(rtb_pkg::TICKS_PER_64 - 1));
      ticks_next.t1 = ticks_next.t64 &&
                      (c1_reg == 6'(rtb_pkg::P64_PER_SEC - 1));
      ticks_next.t60 = ticks_next.t1 &&
                       (cmin_reg == 6'(rtb_pkg::PER_MIN - 1));
      ticks_next.t3600 = ticks_next.t60 &&
                         (chr_reg == 6'(rtb_pkg::PER_MIN - 1));
      base_next = ticks_next.t8k ? 16'h0000 : base_reg + 16'h0001;
      c4k_next = ticks_next.t8k ? c4k_reg + 1'b1 : c4k_reg;
      c64_next = ticks_next.t8k ? c64_reg + 7'h01 : c64_reg;
      c1_next = ticks_next.t64 ? c1_reg + 6'h01 : c1_reg;
      cmin_next = step6(cmin_reg, ticks_next.t1);
      chr_next = step6(chr_reg, ticks_next.t60);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         base_reg <= 16'h0000;
         c4k_reg <= 1'b0;
         c64_reg <= 7'h00;
         c1_reg <= 6'h00;
         cmin_reg <= 6'h00;
         chr_reg <= 6'h00;
         ticks_reg <= '0;
      end else begin
         base_reg <= base_next;
         c4k_reg <= c4k_next;
         c64_reg <= c64_next;
         c1_reg <= c1_next;
         cmin_reg <= cmin_next;
         chr_reg <= chr_next;
         ticks_reg <= ticks_next;
      end
   end

   assign ticks_o = ticks_reg;

endmodule

// File: verilog/rtb_pulse.sv
`timescale 1ns/1ps
module rtb_pulse (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // trigger and width in ticks
   input wire logic start_i,
   input wire logic [11:0] width_i,
   input wire logic tick_i,
   // pulse level
   output logic active_o
);

   logic [11:0] cnt_reg, cnt_next;

   // a new start retriggers the full width
   always_comb begin
      cnt_next = cnt_reg;
      if (start_i) begin
         cnt_next = width_i;
      end else if (tick_i && cnt_reg != 12'h000) begin
         cnt_next = cnt_reg - 12'h001;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_reg <= 12'h000;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   assign active_o = (cnt_reg != 12'h000);

endmodule

// File: verilog/rtb_timer_b_sec.sv
// What this block does
// R1 - timer B countdown only, gated by run bit
// R2 - counts down from written 8-bit preset
// R3 - at count 1: set flag, reload, restart
// R4 - enabled flag drives both interrupt outputs
// R5 - flag set each period, host clears only
// R6 - value read returns live count
// R7 - host should read count twice, compare
// R8 - preset write takes effect at once
// R9 - host should halt timer before preset change
// R10 - count of zero stops timer B
// R11 - pulse select: pulse per period or level
// R12 - seconds flag and interrupt only when enabled
// R13 - seconds pulse lasts one 64 Hz period
// R14 - seconds interrupt: pulse or level by select
// R15 - seconds flag cleared only by host
// R16 - short widths at 4096 and 64 Hz
// R17 - timer B width from width select, fallback
// R18 - clearing flag ends pulse early
// R19 - 3-bit source select, 1/3600 Hz default
// R20 - write 0 clears flag, 1 leaves it
`timescale 1ns/1ps
module rtb_timer_b_sec #(
   parameter int unsigned CYC_TICK = rtb_pkg::CYC_TICK
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // register port from the serial interface
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // open-drain interrupt pins, active low
   output logic irq_out_primary_o,
   output logic irq_out_primary_oe_o,
   output logic irq_out_secondary_o,
   output logic irq_out_secondary_oe_o
);

   ////////////////////////////////////////////////////////////////////////
   rtb_pkg::rtb_ctrl_t ctrl_reg, ctrl_next;
   rtb_pkg::rtb_ticks_t ticks;
   logic [7:0] preset_reg, preset_next;
   logic [7:0] count_reg, count_next;
   logic [7:0] rdata_reg, rdata_next;
   logic b_flag_reg, b_flag_next;
   logic sec_flag_reg, sec_flag_next;
   logic oe1_reg, oe1_next;
   logic oe2_reg, oe2_next;
   logic wr_primary, wr_flags, wr_clkout, wr_freq, wr_value;
   logic src_tick, b_expire, sec_set, b_pulse, sec_pulse;
   logic b_irq, sec_irq;
   logic [11:0] b_width;

   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] b);
      hit = (a == b);
   endfunction

   function automatic logic pick_tick(input rtb_pkg::rtb_ticks_t t,
                                      input logic [2:0] sel);
      case (sel)
         rtb_pkg::SRC_4K: pick_tick = t.t4k;
         rtb_pkg::SRC_64: pick_tick = t.t64;
         rtb_pkg::SRC_1: pick_tick = t.t1;
         rtb_pkg::SRC_60: pick_tick = t.t60;
         default: pick_tick = t.t3600;
      endcase
   endfunction

   function automatic logic [11:0] pulse_width(input logic [2:0] sel,
                                               input logic [7:0] tv,
                                               input logic [2:0] tbw);
      logic [11:0] set_w;
      logic [15:0] period;
      set_w = 12'(tbw) << rtb_pkg::TBW_STEP_SHIFT;
      // low codes share one floor width so no setting gives a null pulse
      if (set_w < rtb_pkg::W_TBW_BASE) begin
         set_w = rtb_pkg::W_TBW_BASE;
      end
      period = 16'(tv) << rtb_pkg::P64_SHIFT;
      case (sel)
         rtb_pkg::SRC_4K: begin
            pulse_width = (tv == rtb_pkg::COUNT_LAST) ?
                          rtb_pkg::W_122US : rtb_pkg::W_244US; // R16
         end
         rtb_pkg::SRC_64: begin
            if (tv == rtb_pkg::COUNT_LAST) begin
               pulse_width = rtb_pkg::W_7812US; // R16
            end else if (period < 16'(set_w)) begin
               pulse_width = rtb_pkg::W_15625US; // R17
            end else begin
               pulse_width = set_w;
            end
         end
         default: pulse_width = set_w; // R17
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // prescaler and pulse generators
   rtb_prescaler #(.CYC_TICK(CYC_TICK)) u_prescaler (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .ticks_o(ticks)
   );

   rtb_pulse u_b_pulse (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(b_expire),
      .width_i(b_width),
      .tick_i(ticks.t8k),
      .active_o(b_pulse)
   );

   // measured in 8 kHz ticks: exactly one 64 Hz period
   rtb_pulse u_sec_pulse (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(sec_set),
      .width_i(rtb_pkg::W_15625US), // R13
      .tick_i(ticks.t8k),
      .active_o(sec_pulse)
   );

   ////////////////////////////////////////////////////////////////////////
   // control registers
   assign wr_primary = reg_wr_i && hit(reg_addr_i, rtb_pkg::ADDR_PRIMARY_CTRL);
   assign wr_flags = reg_wr_i && hit(reg_addr_i, rtb_pkg::ADDR_FLAG_CTRL);
   assign wr_clkout = reg_wr_i && hit(reg_addr_i, rtb_pkg::ADDR_TMR_CLKOUT);
   assign wr_freq = reg_wr_i && hit(reg_addr_i, rtb_pkg::ADDR_TMR_B_FREQ);
   assign wr_value = reg_wr_i && hit(reg_addr_i, rtb_pkg::ADDR_TMR_B_VALUE);

   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_primary) begin
         ctrl_next.sec_irq_en = reg_wdata_i[rtb_pkg::BIT_SEC_IRQ_EN];
      end
      if (wr_flags) begin
         ctrl_next.b_irq_en = reg_wdata_i[rtb_pkg::BIT_B_IRQ_EN];
      end
      if (wr_clkout) begin
         ctrl_next.a_pulse_sel = reg_wdata_i[rtb_pkg::BIT_A_PULSE_SEL];
         ctrl_next.b_pulse_sel = reg_wdata_i[rtb_pkg::BIT_B_PULSE_SEL];
         ctrl_next.b_run = reg_wdata_i[rtb_pkg::BIT_B_RUN];
      end
      if (wr_freq) begin
         ctrl_next.b_width_sel =
            reg_wdata_i[rtb_pkg::WIDTH_LSB +: rtb_pkg::SEL_W];
         ctrl_next.b_src_sel =
            reg_wdata_i[rtb_pkg::SRC_LSB +: rtb_pkg::SEL_W]; // R19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // timer B countdown
   assign src_tick = pick_tick(ticks, ctrl_reg.b_src_sel); // R19
   assign b_width = pulse_width(ctrl_reg.b_src_sel, preset_reg,
                                ctrl_reg.b_width_sel);

   always_comb begin
      preset_next = preset_reg;
      count_next = count_reg;
      b_expire = 1'b0;
      if (wr_value) begin
         // no sync to the source tick: first period may be short
         preset_next = reg_wdata_i; // R2
         count_next = reg_wdata_i; // R8
      end else if (wr_clkout && reg_wdata_i[rtb_pkg::BIT_B_RUN] &&
                   !ctrl_reg.b_run) begin
         count_next = preset_reg;
      end else if (ctrl_reg.b_run && src_tick &&
                   count_reg != rtb_pkg::COUNT_STOP) begin // R1 R10
         if (count_reg == rtb_pkg::COUNT_LAST) begin
            count_next = preset_reg; // R3
            b_expire = 1'b1;
         end else begin
            count_next = count_reg - rtb_pkg::COUNT_LAST;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: the set wins over a clear in the same cycle
   assign sec_set = ctrl_reg.sec_irq_en && ticks.t1; // R12

   always_comb begin
      b_flag_next = b_flag_reg;
      sec_flag_next = sec_flag_reg;
      if (wr_flags) begin
         b_flag_next = b_flag_reg && reg_wdata_i[rtb_pkg::BIT_B_FLAG]; // R20
         sec_flag_next = sec_flag_reg &&
                         reg_wdata_i[rtb_pkg::BIT_SEC_FLAG]; // R15
      end
      if (b_expire) begin
         b_flag_next = 1'b1; // R5
      end
      if (sec_set) begin
         sec_flag_next = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt outputs; pulse is gated by its flag so a clear cuts it
   assign b_irq = ctrl_reg.b_irq_en && b_flag_reg &&
                  (!ctrl_reg.b_pulse_sel || b_pulse); // R4 R11 R18
   assign sec_irq = ctrl_reg.sec_irq_en && sec_flag_reg &&
                    (!ctrl_reg.a_pulse_sel || sec_pulse); // R14 R18

   always_comb begin
      oe1_next = b_irq || sec_irq; // R4
      oe2_next = b_irq;
   end

   ////////////////////////////////////////////////////////////////////////
   // register reads, answered on the cycle after the strobe
   always_comb begin
      rdata_next = rdata_reg;
      if (reg_rd_i) begin
         rdata_next = 8'h00;
         case (reg_addr_i)
            rtb_pkg::ADDR_PRIMARY_CTRL: begin
               rdata_next[rtb_pkg::BIT_SEC_IRQ_EN] = ctrl_reg.sec_irq_en;
            end
            rtb_pkg::ADDR_FLAG_CTRL: begin
               rdata_next[rtb_pkg::BIT_B_IRQ_EN] = ctrl_reg.b_irq_en;
               rdata_next[rtb_pkg::BIT_SEC_FLAG] = sec_flag_reg;
               rdata_next[rtb_pkg::BIT_B_FLAG] = b_flag_reg;
            end
            rtb_pkg::ADDR_TMR_CLKOUT: begin
               rdata_next[rtb_pkg::BIT_A_PULSE_SEL] = ctrl_reg.a_pulse_sel;
               rdata_next[rtb_pkg::BIT_B_PULSE_SEL] = ctrl_reg.b_pulse_sel;
               rdata_next[rtb_pkg::BIT_B_RUN] = ctrl_reg.b_run;
            end
            rtb_pkg::ADDR_TMR_B_FREQ: begin
               rdata_next[rtb_pkg::WIDTH_LSB +: rtb_pkg::SEL_W] =
                  ctrl_reg.b_width_sel;
               rdata_next[rtb_pkg::SRC_LSB +: rtb_pkg::SEL_W] =
                  ctrl_reg.b_src_sel;
            end
            // not frozen: host must tolerate a tick between reads
            rtb_pkg::ADDR_TMR_B_VALUE: rdata_next = count_reg; // R6
            default: rdata_next = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_reg <= '0;
         ctrl_reg.b_src_sel <= rtb_pkg::SRC_RST;
         ctrl_reg.b_width_sel <= rtb_pkg::WIDTH_RST;
         preset_reg <= rtb_pkg::COUNT_RST;
         count_reg <= rtb_pkg::COUNT_RST;
         b_flag_reg <= 1'b0;
         sec_flag_reg <= 1'b0;
         oe1_reg <= 1'b0;
         oe2_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         ctrl_reg <= ctrl_next;
         preset_reg <= preset_next;
         count_reg <= count_next;
         b_flag_reg <= b_flag_next;
         sec_flag_reg <= sec_flag_next;
         oe1_reg <= oe1_next;
         oe2_reg <= oe2_next;
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign irq_out_primary_o = 1'b0;
   assign irq_out_secondary_o = 1'b0;
   assign irq_out_primary_oe_o = oe1_reg;
   assign irq_out_secondary_oe_o = oe2_reg;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   a_halt_holds: assert property ( // R1
      !ctrl_reg.b_run && !reg_wr_i |=> $stable(count_reg))
      else $error("timer B moved while halted");

   a_preset_write: assert property ( // R8
      wr_value |=> count_reg == $past(reg_wdata_i) &&
                   preset_reg == $past(reg_wdata_i))
      else $error("preset write not applied at once");

   a_reload_flag: assert property ( // R3
      ctrl_reg.b_run && src_tick && count_reg == rtb_pkg::COUNT_LAST &&
      !reg_wr_i |=> b_flag_reg && count_reg == $past(preset_reg))
      else $error("no reload or flag at end of period");

   a_b_level_irq: assert property ( // R4
      ctrl_reg.b_irq_en && b_flag_reg && !ctrl_reg.b_pulse_sel
      |=> irq_out_secondary_oe_o && irq_out_primary_oe_o)
      else $error("timer B level interrupt missing");

   a_b_flag_sticky: assert property ( // R5
      b_flag_reg && !wr_flags |=> b_flag_reg)
      else $error("timer B flag dropped without host");

   a_live_read: assert property ( // R6
      reg_rd_i && reg_addr_i == rtb_pkg::ADDR_TMR_B_VALUE
      |=> reg_rdata_o == $past(count_reg))
      else $error("value read not the live count");

   a_zero_stops: assert property ( // R10
      count_reg == rtb_pkg::COUNT_STOP && !reg_wr_i
      |=> count_reg == rtb_pkg::COUNT_STOP && !b_expire)
      else $error("timer B ran from zero");

   a_sec_never_set: assert property ( // R12
      !ctrl_reg.sec_irq_en && !sec_flag_reg |=> !sec_flag_reg)
      else $error("seconds flag set while disabled");

   a_sec_level: assert property ( // R14
      ctrl_reg.sec_irq_en && sec_flag_reg && !ctrl_reg.a_pulse_sel
      |=> irq_out_primary_oe_o)
      else $error("seconds level interrupt missing");

   a_early_end: assert property ( // R18
      !b_flag_reg && !sec_flag_reg |=> !irq_out_primary_oe_o)
      else $error("interrupt outlived its flags");

   a_flag_clear: assert property ( // R20
      wr_flags && !reg_wdata_i[rtb_pkg::BIT_B_FLAG] && !b_expire
      |=> !b_flag_reg)
      else $error("write of 0 did not clear flag");

endmodule

// File: dv/rtb_host_model.sv
`timescale 1ns/1ps
module rtb_host_model (
   // clock
   input wire logic sys_clk_i,
   // register port toward the device
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   input wire logic [7:0] reg_rdata_i
);
   initial begin
      reg_addr_o = 8'h5a;
      reg_wdata_o = 8'ha5;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   // idle address and data are inverted so stale values never match
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1 d = reg_rdata_i;
   endtask
   // live count is not frozen, so read in pairs until two agree, giving up after four pairs
   task automatic rd_twice(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] e;
      d = 8'h00;
      e = 8'hff;
      for (int i = 0; i < 4 && d !== e; i++) begin
         rd_reg(a, d);
         rd_reg(a, e);
      end
   endtask
   // zero clears the chosen flag, ones leave the other flag
   task automatic clr_flag(input int unsigned b, input logic en);
      wr_reg(rtb_pkg::ADDR_FLAG_CTRL,
         (8'h30 & ~(8'h01 << b)) | {7'h00, en});
   endtask
   task automatic set_preset(input logic [7:0] v, input logic [7:0] ctl);
      wr_reg(rtb_pkg::ADDR_TMR_CLKOUT, ctl & 8'hfe);
      wr_reg(rtb_pkg::ADDR_TMR_B_VALUE, v);
   endtask
endmodule

// File: dv/rtb_timer_b_sec_tb.sv
`timescale 1ns/1ps
module rtb_timer_b_sec_tb;
   localparam int unsigned CYC = 4;
   localparam logic [7:0] A_CTL = rtb_pkg::ADDR_PRIMARY_CTRL;
   localparam logic [7:0] A_FLG = rtb_pkg::ADDR_FLAG_CTRL;
   localparam logic [7:0] A_TCO = rtb_pkg::ADDR_TMR_CLKOUT;
   localparam logic [7:0] A_FRQ = rtb_pkg::ADDR_TMR_B_FREQ;
   localparam logic [7:0] A_VAL = rtb_pkg::ADDR_TMR_B_VALUE;
   logic sys_clk_i;
   logic sys_rst_i;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, irq1, irq1_oe, irq2, irq2_oe;
   int num_errors = 0;
   int n_tests = 0;
   int n;
   rtb_timer_b_sec #(.CYC_TICK(CYC)) dut (
      .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_rdata_o(rdata),
      .irq_out_primary_o(irq1), .irq_out_primary_oe_o(irq1_oe),
      .irq_out_secondary_o(irq2), .irq_out_secondary_oe_o(irq2_oe)
   );
   rtb_host_model host (
      .sys_clk_i(sys_clk_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
      .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata)
   );
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic in_range(input int v, input int lo, input int hi);
      check({7'h00, v >= lo && v <= hi}, 8'h01);
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // bounded wait for an enable to reach lvl; n is cycles taken
   task automatic wait_oe(input logic sec, input logic lvl, input int lim);
      n = 0;
      while (((sec ? irq2_oe : irq1_oe) !== lvl) && n < lim) begin
         @(posedge sys_clk_i);
         #1 n++;
      end
      if (n >= lim) begin
         num_errors++;
         $display("wrong value at %0t: wait ran out", $time);
         finish_test();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      host.rd_reg(A_TCO, d);
      check(d, 8'h00);
      host.rd_reg(A_FRQ, d);
      check(d, 8'h07);
      host.rd_reg(A_VAL, d);
      check(d, 8'h00);
      host.rd_reg(A_FLG, d);
      check(d, 8'h00);
      check({irq1, irq1_oe, irq2, irq2_oe}, 8'h00);
   endtask
   // 64 Hz source, preset 3, level mode
   task automatic t_level();
      host.wr_reg(A_FRQ, 8'h01);
      host.wr_reg(A_FLG, 8'h31);
      host.set_preset(8'h03, 8'h00);
      host.wr_reg(A_TCO, 8'h01);
      repeat (600) @(posedge sys_clk_i);
      host.rd_twice(A_VAL, d);
      in_range(d, 1, 2);
      wait_oe(1, 1, 2000);
      check({7'h00, irq1_oe}, 8'h01);
      host.rd_reg(A_VAL, d);
      in_range(d, 2, 3);
      repeat (50) @(posedge sys_clk_i);
      check({6'h00, irq1_oe, irq2_oe}, 8'h03);
      host.wr_reg(A_TCO, 8'h00);
      host.wr_reg(A_FLG, 8'h30);
      wait_oe(1, 0, 4);
      host.rd_reg(A_FLG, d);
      check(d, 8'h20);
      host.clr_flag(5, 1'b1);
      host.rd_reg(A_FLG, d);
      check(d, 8'h01);
   endtask
   // 4096 Hz, preset 1, pulse mode: one tick wide
   task automatic t_pulse();
      host.wr_reg(A_FRQ, 8'h00);
      host.set_preset(8'h01, 8'h40);
      host.wr_reg(A_TCO, 8'h41);
      wait_oe(1, 1, 100);
      wait_oe(1, 0, 20);
      in_range(n, 1, 2 * CYC + 1);
      host.wr_reg(A_TCO, 8'h40);
      host.rd_reg(A_FLG, d);
      check(d, 8'h21);
      host.clr_flag(5, 1'b1);
   endtask
   // long pulse cut short by clearing the flag
   task automatic t_early();
      host.wr_reg(A_FRQ, 8'h01);
      host.set_preset(8'h03, 8'h40);
      host.wr_reg(A_TCO, 8'h41);
      wait_oe(1, 1, 2000);
      repeat (20) @(posedge sys_clk_i);
      host.wr_reg(A_TCO, 8'h40);
      host.clr_flag(5, 1'b1);
      wait_oe(1, 0, 6);
   endtask
   // on-the-fly preset, reload of new value, then zero stops
   task automatic t_preset();
      host.set_preset(8'hc8, 8'h00);
      host.wr_reg(A_TCO, 8'h01);
      repeat (100) @(posedge sys_clk_i);
      host.wr_reg(A_VAL, 8'h05);
      host.rd_reg(A_VAL, d);
      in_range(d, 4, 5);
      wait_oe(1, 1, 3600);
      host.rd_reg(A_VAL, d);
      check(d, 8'h05);
      host.wr_reg(A_VAL, 8'h00);
      host.clr_flag(5, 1'b1);
      repeat (1100) @(posedge sys_clk_i);
      host.rd_reg(A_FLG, d);
      check(d, 8'h01);
      host.rd_reg(A_VAL, d);
      check(d, 8'h00);
   endtask
   // seconds interrupt in pulse mode on the primary pin only
   task automatic t_seconds();
      host.wr_reg(A_TCO, 8'h80);
      host.wr_reg(A_FLG, 8'h30);
      host.wr_reg(A_CTL, 8'h04);
      wait_oe(0, 1, 40000);
      check({7'h00, irq2_oe}, 8'h00);
      wait_oe(0, 0, 700);
      in_range(n, 128 * CYC - CYC - 2, 128 * CYC + 2);
      host.rd_reg(A_FLG, d);
      check(d, 8'h10);
      host.clr_flag(4, 1'b0);
      host.rd_reg(A_FLG, d);
      check(d, 8'h00);
      // level mode, timer B on the 1 Hz source firing on the same tick
      host.wr_reg(A_TCO, 8'h00);
      host.wr_reg(A_FRQ, 8'h02);
      host.wr_reg(A_VAL, 8'h01);
      host.wr_reg(A_FLG, 8'h31);
      host.wr_reg(A_TCO, 8'h01);
      wait_oe(0, 1, 40000);
      // past one seconds pulse width: level must still stand
      repeat (600) @(posedge sys_clk_i);
      check({6'h00, irq1_oe, irq2_oe}, 8'h03);
      host.rd_reg(A_FLG, d);
      check(d, 8'h31);
      host.clr_flag(4, 1'b1);
      check({6'h00, irq1_oe, irq2_oe}, 8'h03);
      host.clr_flag(5, 1'b0);
      wait_oe(0, 0, 4);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst_i = 1'b1;
      repeat (12) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      t_level();
      t_pulse();
      t_early();
      t_preset();
      t_seconds();
      finish_test();
   end
endmodule
